// ### verif/ssp_far.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// far side: slave device on the shared clock
// ----------------------------------------
// behavioural slave; the master makes every edge, so no clock of its own
module ssp_far (
	input wire logic en,
	input wire logic pol,
	input wire logic [3:0] nb,
	input wire logic [8:0] pat,
	input wire logic ck,
	input wire logic dt,
	output logic dout,
	output logic [3:0] cnt,
	output logic [7:0] nchar,
	output logic [8:0] last
);
	logic [8:0] sr;
	logic [3:0] idx;

	// start quiet, no characters seen
	initial begin
		nchar = 8'h00;
		dout = 1'b0;
		cnt = 4'h0;
		idx = 4'h0;
	end

	// disabled: forget any partial character
	always @(negedge en) begin
		cnt = 4'h0;
		idx = 4'h0;
	end

	// leading edge moves away from the idle level, trailing edge back to it
	always @(ck) begin
		if (en && ck === !pol) begin
			dout = pat[idx];
			idx = (idx == nb - 4'h1) ? 4'h0 : idx + 4'h1;
		end else if (en && ck === pol) begin
			sr = {dt, sr[8:1]};
			cnt = cnt + 4'h1;
			if (cnt == nb) begin
				last = sr >> (4'h9 - nb);
				nchar = nchar + 8'h1;
				cnt = 4'h0;
			end
		end
	end
endmodule : ssp_far

`default_nettype wire

// ### verif/sync_serial_master_slave_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module sync_serial_master_slave_port_tb
	import ssp_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic clock_pin_out, clock_pin_oe_b, data_pin_out, data_pin_oe_b;
	logic ck_line, dt_line, f_dout;
	logic flip = 1'b0;
	logic b_ck = 1'b1;
	logic f_en = 1'b0, f_pol = 1'b0, f_talk = 1'b0;
	logic [3:0] f_nb = 4'h8, f_cnt;
	logic [7:0] f_nchar, d1, d2, t;
	logic [8:0] f_last, e1;
	logic [8:0] pat = 9'h000;
	logic [15:0] note_q[$];
	logic [15:0] note;
	logic rd_seen = 1'b0;
	logic [31:0] seed = 32'd91995;
	int err_total = 0, compares = 0, cyc = 0;

	// released clock pin: pull-up, or the bench acting as link master
	// a released data line is driven by the far side while f_talk is set, else it wanders every cycle
	assign ck_line = clock_pin_oe_b ? b_ck : clock_pin_out;
	assign dt_line = !data_pin_oe_b ? data_pin_out : (f_talk ? f_dout : flip);

	ssp_port i_dut (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.clock_pin_in(ck_line), .clock_pin_out(clock_pin_out),
		.clock_pin_oe_b(clock_pin_oe_b), .data_pin_in(dt_line),
		.data_pin_out(data_pin_out), .data_pin_oe_b(data_pin_oe_b)
	);

	ssp_far i_far (
		.en(f_en), .pol(f_pol), .nb(f_nb), .pat(pat), .ck(ck_line), .dt(dt_line),
		.dout(f_dout), .cnt(f_cnt), .nchar(f_nchar), .last(f_last)
	);

	always #4 clk = ~clk;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic results();
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// read data is ready in the cycle after the strobe and is checked there
	always @(posedge clk) begin
		if (rd_seen) begin
			note = note_q.pop_front();
			`CHK(reg_rdata & note[15:8], note[7:0])
		end
		rd_seen <= reg_rd;
		flip <= ~flip;
	end

	// hang guard, far above the few thousand cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// ----------------------------------------
	// register port and link helpers
	// ----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// expected value and mask go on the queue; only masked bits are judged
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		note_q.push_back({m, e & m});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic chk_char(input logic [7:0] n, input logic [8:0] e);
		for (int k = 0; k < 3000 && f_nchar !== n; k++) begin
			@(posedge clk);
		end
		`CHK({f_nchar, f_last}, {n, e})
		repeat (8) @(posedge clk);
	endtask : chk_char

	// port off first, so each setup also starts from a cleared port
	task automatic setup(input logic p, input logic [7:0] rxs, input logic [7:0] txs);
		f_en <= 1'b0;
		wr(`SSP_OFF_RX_STAT, 8'h00);
		wr(`SSP_OFF_TX_STAT, 8'h00);
		@(posedge clk);
		`CHK({clock_pin_oe_b, data_pin_oe_b}, 2'b11)
		// setup order; divisor 9 gives a 160 ns bit clock
		wr(`SSP_OFF_BAUD_CTL, {3'h0, p, 4'h0});
		wr(`SSP_OFF_DIV_LO, 8'h09);
		wr(`SSP_OFF_DIV_HI, 8'h00);
		wr(`SSP_OFF_RX_STAT, rxs);
		wr(`SSP_OFF_TX_STAT, txs);
		repeat (4) @(posedge clk);
		f_pol <= p;
		f_nb <= (rxs[6] | txs[6]) ? 4'h9 : 4'h8;
		f_en <= 1'b1;
		@(posedge clk);
		`CHK({clock_pin_oe_b, ck_line}, {1'b0, p})
	endtask : setup

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		`CHK({clock_pin_oe_b, data_pin_oe_b}, 2'b11)
		rd(`SSP_OFF_FLAGS, 8'h01, 8'h03);
		rd(`SSP_OFF_TX_STAT, 8'h02, 8'h02);
		rd(`SSP_OFF_RX_TOP, 8'h00, 8'hff);
		d1 = 8'(xs());
		d2 = 8'(xs());
		wr(`SSP_OFF_DIV_LO, d1);
		wr(`SSP_OFF_DIV_HI, d2);
		wr(`SSP_OFF_BAUD_CTL, d1);
		wr(`SSP_OFF_FLAGS, 8'hff);
		wr(`SSP_OFF_TX_STAT, 8'hff);
		wr(`SSP_OFF_RX_STAT, 8'h7f);
		rd(`SSP_OFF_DIV_LO, d1, 8'hff);
		rd(`SSP_OFF_DIV_HI, d2, 8'hff);
		rd(`SSP_OFF_BAUD_CTL, d1, 8'h18);
		rd(`SSP_OFF_FLAGS, 8'h01, 8'h03);
		rd(`SSP_OFF_TX_STAT, 8'hf7, 8'hf7);
		rd(`SSP_OFF_RX_STAT, 8'h70, 8'hf3);
		$display("test registers done");

		// two back-to-back characters, both polarities, 8 and 9 bits
		for (int i = 0; i < 2; i++) begin
			f_talk <= 1'b0;
			setup(i[0], 8'h80, 8'hb0 | (i[0] ? 8'h41 : 8'h00));
			`CHK({clock_pin_oe_b, data_pin_oe_b}, 2'b00)
			d1 = 8'(xs());
			d2 = 8'(xs());
			t = f_nchar;
			wr(`SSP_OFF_TX_DATA, d1);
			wr(`SSP_OFF_TX_DATA, d2);
			rd(`SSP_OFF_FLAGS, 8'h00, 8'h01);
			rd(`SSP_OFF_TX_STAT, 8'h00, 8'h02);
			chk_char(t + 8'h1, {i[0], d1});
			chk_char(t + 8'h2, {i[0], d2});
			rd(`SSP_OFF_TX_STAT, 8'h02, 8'h02);
			rd(`SSP_OFF_FLAGS, 8'h01, 8'h01);
			repeat (80) @(posedge clk);
			`CHK({f_nchar, f_cnt}, {t + 8'h2, 4'h0})
			$display("test transmit done");
		end

		// slave transmit on a bench clock
		setup(1'b1, 8'h80, 8'hb0);
		wr(`SSP_OFF_TX_STAT, 8'h30);
		d1 = 8'(xs());
		t = f_nchar;
		wr(`SSP_OFF_TX_DATA, d1);
		`CHK({clock_pin_oe_b, data_pin_oe_b}, 2'b10)
		// idle high, so the falling edge leads; 160 ns per bit
		repeat (8) begin
			repeat (10) @(posedge clk);
			b_ck <= 1'b0;
			repeat (10) @(posedge clk);
			b_ck <= 1'b1;
		end
		chk_char(t + 8'h1, {1'b0, d1});
		rd(`SSP_OFF_TX_STAT, 8'h02, 8'h02);
		$display("test slave transmit done");

		// single receive with transmit enable still set
		for (int i = 0; i < 2; i++) begin
			pat = 9'(xs());
			f_talk <= 1'b1;
			setup(i[0], 8'h80 | {1'b0, i[0], 6'h0}, 8'hb0);
			t = f_nchar;
			wr(`SSP_OFF_RX_STAT, 8'ha0 | {1'b0, i[0], 6'h0});
			repeat (2) @(posedge clk);
			`CHK({clock_pin_oe_b, data_pin_oe_b}, 2'b01)
			e1 = i[0] ? pat : {1'b0, pat[7:0]};
			chk_char(t + 8'h1, e1);
			rd(`SSP_OFF_RX_STAT, {1'b1, i[0], 5'h0, e1[8]}, 8'hf3);
			rd(`SSP_OFF_FLAGS, 8'h02, 8'h02);
			rd(`SSP_OFF_RX_TOP, pat[7:0], 8'hff);
			rd(`SSP_OFF_FLAGS, 8'h00, 8'h02);
			repeat (80) @(posedge clk);
			`CHK(f_nchar, t + 8'h1)
			$display("test single receive done");
		end

		// both enables, then a third character into a full fifo
		pat = 9'(xs());
		setup(1'b0, 8'h80, 8'hb0);
		t = f_nchar;
		wr(`SSP_OFF_RX_STAT, 8'hb0);
		chk_char(t + 8'h1, {1'b0, pat[7:0]});
		rd(`SSP_OFF_RX_STAT, 8'h90, 8'hf0);
		chk_char(t + 8'h3, {1'b0, pat[7:0]});
		rd(`SSP_OFF_RX_STAT, 8'h92, 8'hf2);
		repeat (100) @(posedge clk);
		`CHK(f_nchar, t + 8'h3)
		rd(`SSP_OFF_RX_TOP, pat[7:0], 8'hff);
		rd(`SSP_OFF_RX_TOP, pat[7:0], 8'hff);
		rd(`SSP_OFF_RX_STAT, 8'h92, 8'hf2);
		wr(`SSP_OFF_RX_STAT, 8'h80);
		rd(`SSP_OFF_RX_STAT, 8'h80, 8'hf2);
		$display("test overrun done");

		// continuous receive dropped after three bits
		t = f_nchar;
		wr(`SSP_OFF_RX_STAT, 8'h90);
		for (int k = 0; k < 500 && f_cnt != 4'h3; k++) begin
			@(posedge clk);
		end
		wr(`SSP_OFF_RX_STAT, 8'h80);
		repeat (10) @(posedge clk);
		`CHK(ck_line, 1'b0)
		repeat (80) @(posedge clk);
		`CHK(f_nchar, t)
		rd(`SSP_OFF_FLAGS, 8'h00, 8'h02);
		$display("test abort done");
		results();
	end
endmodule : sync_serial_master_slave_port_tb

`default_nettype wire

// ### verilog/ssp_baud.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.svh"

// half bit period timer: one tick every limit+1 clocks while run is high (limit is divisor, or its low byte in narrow mode)
module ssp_baud (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [15:0] divisor,
	input wire logic wide,
	output logic tick
);

	logic [15:0] cnt;
	logic [15:0] limit;

	// narrow counter mode only uses the low byte
	assign limit = wide ? divisor : {8'h00, divisor[7:0]};

	// count restarts whenever the engine stops, so every frame starts alike
	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt <= `SSP_RST_DIV;
			tick <= 1'b0;
		end else if (cnt == limit) begin
			cnt <= `SSP_RST_DIV;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// no tick without a running engine
	tick_run_a: assert property (@(posedge clk) disable iff (!rst_b)
		!run |=> !tick)
		else $error("baud tick while stopped");

endmodule : ssp_baud

`default_nettype wire

// ### verilog/ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// register offsets on the plain register port
`define SSP_ADDR_W 3
`define SSP_OFF_BAUD_CTL 3'h0
`define SSP_OFF_RX_STAT 3'h1
`define SSP_OFF_DIV_LO 3'h2
`define SSP_OFF_DIV_HI 3'h3
`define SSP_OFF_TX_DATA 3'h4
`define SSP_OFF_TX_STAT 3'h5
`define SSP_OFF_RX_TOP 3'h6
`define SSP_OFF_FLAGS 3'h7

// baud_control bits
`define SSP_B_POL 4
`define SSP_B_WIDE 3
// receive_status_control bits
`define SSP_B_PEN 7
`define SSP_B_RX9 6
`define SSP_B_SRE 5
`define SSP_B_CRE 4
`define SSP_B_OVR 1
`define SSP_B_RX_NINTH_BIT_VALUE 0
// transmit_status_control bits
`define SSP_B_MST 7
`define SSP_B_TX9 6
`define SSP_B_TRANSMIT_ENABLE 5
`define SSP_B_SYNC 4
`define SSP_B_HSB 2
`define SSP_B_SHIFTER_EMPTY_FLAG 1
`define SSP_B_TX_NINTH_BIT_VALUE 0
// flags register bits
`define SSP_B_PEND 1
`define SSP_B_TBE 0

// character lengths and reset values
`define SSP_BITS_8 4'h8
`define SSP_BITS_9 4'h9
`define SSP_RST_BYTE 8'h00
`define SSP_RST_CHAR 9'h000
`define SSP_RST_CNT 4'h0
`define SSP_RST_DIV 16'h0000

`endif

// ### verilog/ssp_pkg.sv
// ----------------------------------------
// shared types
// ----------------------------------------
package ssp_pkg;

	// engine state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX = 3'b010,
		ST_RX = 3'b100
	} ssp_state_t;

endpackage : ssp_pkg

// ### verilog/ssp_port.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.svh"

// Notes on behaviour
// R1 - sync mode select; master when source set
// R2 - transmit only with both receive enables clear
// R3 - port enable off resets receive, transmit
// R4 - master drives clock pin when configured
// R5 - one clock per data bit, no extras
// R6 - polarity sets idle level and change edge
// R7 - no start or stop bits
// R8 - master transmit drives data and clock
// R9 - holding moves to shifter when shifter empty
// R10 - data changes on leading edge only
// R11 - shifter not reachable by software
// R12 - software sets up before writing holding
// R13 - master receive releases data pin
// R14 - single receive: one character, then cleared
// R15 - continuous clocks; clear aborts partial character
// R16 - both set: single cleared, continuous continues
// R17 - sample on trailing edge, push, pending
// R18 - fifo top read gives oldest low byte
// R19 - slave takes clock from pin, undriven
// R20 - third character overruns, fifo kept, stop
// R21 - overrun clear by read or continuous off
// R22 - ninth bit shifted, shown for oldest
// R23 - buffer empty flag set on handover
// R24 - shifter empty flag shows transmitter idle
// R25 - least significant bit first, ninth last
module ssp_port
	import ssp_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [`SSP_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe_b,
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe_b
);

	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	// ----------------------------------------
	// software state
	// ----------------------------------------
	logic clock_polarity, wide_baud_counter;
	logic [7:0] baud_divisor_low, baud_divisor_high;
	logic port_enable, rx_ninth_bit_en, single_receive_en, continuous_receive_en;
	logic clock_source_master, tx_ninth_bit_en, transmit_enable;
	logic clocked_mode_select, high_speed_baud, tx_ninth_bit_value;
	logic [7:0] hold_data;
	logic hold_full;

	// ----------------------------------------
	// engine state
	// ----------------------------------------
	ssp_state_t state;
	logic [8:0] tx_sh, rx_sh;
	logic [3:0] tx_cnt, rx_cnt;
	logic phase, baud_tick, data_out;
	logic ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
	logic overrun_flag, ovr_cont;
	logic [8:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] rd_ptr, wr_ptr;
	logic [CW-1:0] fifo_count;

	logic wr_baud, wr_rxs, wr_lo, wr_hi, wr_txd, wr_txs, rd_top;
	logic sync_on, rx_mode, tx_mode, running;
	logic [3:0] tx_nbits, rx_nbits;
	logic pin_lead, pin_trail, lead_ev, trail_ev;
	logic load, rx_start, tx_done, rx_done, fifo_full, push, pop;
	logic ovr_set, ovr_clr;
	logic [8:0] rx_word, rx_char;

	// register port decode
	assign wr_baud = reg_wr && reg_addr == `SSP_OFF_BAUD_CTL;
	assign wr_rxs = reg_wr && reg_addr == `SSP_OFF_RX_STAT;
	assign wr_lo = reg_wr && reg_addr == `SSP_OFF_DIV_LO;
	assign wr_hi = reg_wr && reg_addr == `SSP_OFF_DIV_HI;
	assign wr_txd = reg_wr && reg_addr == `SSP_OFF_TX_DATA;
	assign wr_txs = reg_wr && reg_addr == `SSP_OFF_TX_STAT;
	assign rd_top = reg_rd && reg_addr == `SSP_OFF_RX_TOP;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// R1 sync and master
	assign sync_on = port_enable && clocked_mode_select;
	// R2 transmit versus receive
	assign rx_mode = single_receive_en || continuous_receive_en;
	assign tx_mode = !rx_mode && transmit_enable;
	// R7 data bits only, no framing
	assign tx_nbits = tx_ninth_bit_en ? `SSP_BITS_9 : `SSP_BITS_8;
	assign rx_nbits = rx_ninth_bit_en ? `SSP_BITS_9 : `SSP_BITS_8;
	assign running = sync_on && clock_source_master && state != ST_IDLE;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// baud and polarity setup
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clock_polarity <= 1'b0;
			wide_baud_counter <= 1'b0;
			baud_divisor_low <= `SSP_RST_BYTE;
			baud_divisor_high <= `SSP_RST_BYTE;
		end else begin
			if (wr_baud) begin
				clock_polarity <= reg_wdata[`SSP_B_POL];
				wide_baud_counter <= reg_wdata[`SSP_B_WIDE];
			end
			if (wr_lo)
				baud_divisor_low <= reg_wdata;
			if (wr_hi)
				baud_divisor_high <= reg_wdata;
		end
	end

	// receive control; a software write beats the hardware clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			port_enable <= 1'b0;
			rx_ninth_bit_en <= 1'b0;
			single_receive_en <= 1'b0;
			continuous_receive_en <= 1'b0;
		end else if (wr_rxs) begin
			port_enable <= reg_wdata[`SSP_B_PEN];
			rx_ninth_bit_en <= reg_wdata[`SSP_B_RX9];
			single_receive_en <= reg_wdata[`SSP_B_SRE];
			continuous_receive_en <= reg_wdata[`SSP_B_CRE];
		// R14 R16 single enable drops after a character
		end else if (rx_done) begin
			single_receive_en <= 1'b0;
		end
	end

	// transmit control
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clock_source_master <= 1'b0;
			tx_ninth_bit_en <= 1'b0;
			transmit_enable <= 1'b0;
			clocked_mode_select <= 1'b0;
			high_speed_baud <= 1'b0;
			tx_ninth_bit_value <= 1'b0;
		end else if (wr_txs) begin
			clock_source_master <= reg_wdata[`SSP_B_MST];
			tx_ninth_bit_en <= reg_wdata[`SSP_B_TX9];
			transmit_enable <= reg_wdata[`SSP_B_TRANSMIT_ENABLE];
			clocked_mode_select <= reg_wdata[`SSP_B_SYNC];
			high_speed_baud <= reg_wdata[`SSP_B_HSB];
			tx_ninth_bit_value <= reg_wdata[`SSP_B_TX_NINTH_BIT_VALUE];
		end
	end

	// holding register; a write in the load cycle keeps it full
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hold_data <= `SSP_RST_BYTE;
			hold_full <= 1'b0;
		end else begin
			if (wr_txd)
				hold_data <= reg_wdata;
			if (wr_txd)
				hold_full <= 1'b1;
			// R3 disabled port drops pending data
			else if (!sync_on)
				hold_full <= 1'b0;
			// R23 handover empties holding
			else if (load)
				hold_full <= 1'b0;
		end
	end

	// ----------------------------------------
	// pin synchronisers and edge finding
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			dt_s1 <= 1'b0;
			dt_s2 <= 1'b0;
		end else begin
			ck_s1 <= clock_pin_in;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			dt_s1 <= data_pin_in;
			dt_s2 <= dt_s1;
		end
	end

	// R19 slave edges come from the pin
	// R6 polarity picks which edge leads
	assign pin_lead = clock_polarity ? (ck_s3 && !ck_s2) : (ck_s2 && !ck_s3);
	assign pin_trail = clock_polarity ? (ck_s2 && !ck_s3) : (ck_s3 && !ck_s2);
	assign lead_ev = clock_source_master ? (baud_tick && !phase) : pin_lead;
	assign trail_ev = clock_source_master ? (baud_tick && phase) : pin_trail;

	// ----------------------------------------
	// master bit clock
	// ----------------------------------------
	ssp_baud u_baud (
		.clk(clk),
		.rst_b(rst_b),
		.run(running),
		.divisor({baud_divisor_high, baud_divisor_low}),
		.wide(wide_baud_counter),
		.tick(baud_tick)
	);

	// R5 R15 phase runs only during a character, stops at once
	always_ff @(posedge clk) begin
		if (!rst_b || !running)
			phase <= 1'b0;
		else if (baud_tick)
			phase <= !phase;
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// R9 load straight away when the shifter is empty
	assign load = state == ST_IDLE && hold_full && tx_mode && sync_on;
	assign rx_start = state == ST_IDLE && rx_mode && sync_on && !overrun_flag;
	assign tx_done = state == ST_TX && trail_ev && tx_cnt == tx_nbits;
	assign rx_done = state == ST_RX && trail_ev && rx_cnt == rx_nbits - 4'h1;
	assign fifo_full = fifo_count == CW'(FIFO_DEPTH);
	assign push = rx_done && !fifo_full;
	assign pop = rd_top && fifo_count != '0;

	// engine state machine
	always_ff @(posedge clk) begin
		// R3 port off returns the engine to idle
		if (!rst_b || !sync_on) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (load)
						state <= ST_TX;
					else if (rx_start)
						state <= ST_RX;
				end
				ST_TX: begin
					if (tx_done || !tx_mode)
						state <= ST_IDLE;
				end
				// R15 leaving receive mode drops the partial character
				ST_RX: begin
					if (!rx_mode)
						state <= ST_IDLE;
					else if (rx_done && (fifo_full || !continuous_receive_en))
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// transmit shifter, never mapped for software
	// ----------------------------------------
	// R11 R25 lsb first, ninth bit last
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_sh <= `SSP_RST_CHAR;
			tx_cnt <= `SSP_RST_CNT;
			data_out <= 1'b0;
		end else if (load) begin
			tx_sh <= {tx_ninth_bit_value, hold_data};
			tx_cnt <= `SSP_RST_CNT;
		// R10 bit changes on the leading edge only
		end else if (state == ST_TX && lead_ev && tx_cnt != tx_nbits) begin
			data_out <= tx_sh[0];
			tx_sh <= {1'b0, tx_sh[8:1]};
			tx_cnt <= tx_cnt + 4'h1;
		end
	end

	// ----------------------------------------
	// receive shifter
	// ----------------------------------------
	assign rx_word = {dt_s2, rx_sh[8:1]};
	// R22 R25 ninth bit arrives last and lands on top
	assign rx_char = rx_ninth_bit_en ? rx_word : {1'b0, rx_word[8:1]};

	// R17 sample on the trailing edge
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rx_sh <= `SSP_RST_CHAR;
			rx_cnt <= `SSP_RST_CNT;
		end else if (state != ST_RX) begin
			rx_cnt <= `SSP_RST_CNT;
		end else if (trail_ev) begin
			rx_sh <= rx_word;
			rx_cnt <= rx_done ? `SSP_RST_CNT : rx_cnt + 4'h1;
		end
	end

	// ----------------------------------------
	// receive fifo
	// ----------------------------------------
	// one storage word per entry
	for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
		always_ff @(posedge clk) begin
			if (!rst_b)
				fifo_mem[i] <= `SSP_RST_CHAR;
			else if (push && wr_ptr == PW'(i))
				fifo_mem[i] <= rx_char;
		end
	end

	// pointers and fill level; a disabled port empties it
	always_ff @(posedge clk) begin
		if (!rst_b || !sync_on) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			fifo_count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			if (pop)
				rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			case ({push, pop})
				2'b10: fifo_count <= fifo_count + CW'(1);
				2'b01: fifo_count <= fifo_count - CW'(1);
				default: fifo_count <= fifo_count;
			endcase
		end
	end

	// ----------------------------------------
	// overrun
	// ----------------------------------------
	// R20 a full fifo keeps its words
	assign ovr_set = rx_done && fifo_full && !overrun_flag;
	// R21 clear path depends on the mode at the error
	assign ovr_clr = ovr_cont ? !continuous_receive_en : rd_top;

	// set beats a same cycle clear
	always_ff @(posedge clk) begin
		if (!rst_b || !sync_on) begin
			overrun_flag <= 1'b0;
			ovr_cont <= 1'b0;
		end else if (ovr_set) begin
			overrun_flag <= 1'b1;
			ovr_cont <= continuous_receive_en;
		end else if (ovr_clr) begin
			overrun_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// read port, data one cycle after the strobe
	// ----------------------------------------
	// R18 R22 R24 status and oldest character
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= `SSP_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`SSP_OFF_BAUD_CTL: reg_rdata <= {3'h0, clock_polarity, wide_baud_counter, 3'h0};
				`SSP_OFF_RX_STAT: reg_rdata <= {port_enable, rx_ninth_bit_en,
					single_receive_en, continuous_receive_en, 2'h0, overrun_flag,
					fifo_count != '0 && fifo_mem[rd_ptr][8]};
				`SSP_OFF_DIV_LO: reg_rdata <= baud_divisor_low;
				`SSP_OFF_DIV_HI: reg_rdata <= baud_divisor_high;
				`SSP_OFF_TX_DATA: reg_rdata <= hold_data;
				`SSP_OFF_TX_STAT: reg_rdata <= {clock_source_master, tx_ninth_bit_en,
					transmit_enable, clocked_mode_select, 1'b0, high_speed_baud,
					state != ST_TX, tx_ninth_bit_value};
				`SSP_OFF_RX_TOP: reg_rdata <= fifo_count != '0 ? fifo_mem[rd_ptr][7:0] : 8'h00;
				`SSP_OFF_FLAGS: reg_rdata <= {6'h00, fifo_count != '0, !hold_full};
				default: reg_rdata <= `SSP_RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	// R4 R8 R13 R19 drivers follow the configured mode
	assign clock_pin_out = clock_polarity ^ phase;
	assign clock_pin_oe_b = !(sync_on && clock_source_master && (tx_mode || rx_mode));
	assign data_pin_oe_b = !(sync_on && tx_mode);
	assign data_pin_out = data_out;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// R6 idle level follows polarity
	clock_idle_a: assert property ( // R6
		state == ST_IDLE ##1 state == ST_IDLE |-> clock_pin_out == clock_polarity)
		else $error("clock not at idle level");

	// R4 master drives clock while busy
	clock_drive_a: assert property ( // R4
		(running && !wr_rxs && !wr_txs) |=> !clock_pin_oe_b || !rx_mode && !tx_mode)
		else $error("clock pin not driven");

	// R13 receive releases data pin
	data_release_a: assert property ( // R13
		state == ST_RX && rx_mode |-> data_pin_oe_b)
		else $error("data pin driven in receive");

	// R14 single enable cleared after a character
	single_clear_a: assert property ( // R14
		rx_done && !wr_rxs |=> !single_receive_en)
		else $error("single receive enable stuck");

	// R20 overrun keeps the fifo full
	overrun_keep_a: assert property ( // R20
		ovr_set && !pop |=> overrun_flag && fifo_count == $past(fifo_count))
		else $error("overrun lost or fifo changed");

	// R17 completed character raises pending
	rx_pend_a: assert property ( // R17
		push && !rd_top |=> fifo_count != '0 ##0 state != ST_TX)
		else $error("pending not raised");

	// R9 holding moves on the next cycle
	tx_load_a: assert property ( // R9
		load && !wr_txd |=> state == ST_TX && !hold_full)
		else $error("holding not handed over");

	// R15 cleared enables stop the clock
	rx_abort_a: assert property ( // R15
		state == ST_RX && !rx_mode |=> state == ST_IDLE ##1 clock_pin_out == clock_polarity)
		else $error("receive did not abort");

	// R3 disabled port empties the fifo
	port_off_a: assert property ( // R3
		!port_enable |=> fifo_count == '0 && state == ST_IDLE && !overrun_flag)
		else $error("port off left state");

	// R10 data moves only after a leading edge
	tx_lead_a: assert property ( // R10
		$changed(data_pin_out) |-> $past(lead_ev) && $past(state) == ST_TX)
		else $error("data changed off the leading edge");

	tx_done_c: cover property (tx_done);
	rx_done_c: cover property (push && continuous_receive_en);
	overrun_c: cover property (ovr_set);
	abort_c: cover property (state == ST_RX && rx_cnt != '0 && !rx_mode);

endmodule : ssp_port

`default_nettype wire
